// [fftc_fill_ctrl.sv]
// receive queue fill sequencer, automatic or manual start
`timescale 1ns/1ps
`default_nettype none
module fftc_fill_ctrl (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic buffer_mode,
    input  wire logic fill_method_select,
    input  wire logic manual_start,
    input  wire logic manual_stop,
    input  wire logic sync_detected,
    input  wire logic fill_stop,
    output var  logic filling,
    output var  logic fill_done
);
    import fftc_pkg::*;

    fftc_fill_state_t state_reg;
    fftc_fill_state_t state_next;

    // next state of the fill sequencer
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            FILL_IDLE: begin
                if (buffer_mode && !fill_method_select && sync_detected) begin
                    state_next = FILL_ACTIVE;
                end else if (buffer_mode && fill_method_select &&
                             manual_start) begin
                    state_next = FILL_WAIT_SYNC;
                end
            end
            FILL_WAIT_SYNC: begin
                if (!buffer_mode || manual_stop) begin
                    state_next = FILL_IDLE;
                end else if (sync_detected) begin
                    state_next = FILL_ACTIVE;
                end
            end
            FILL_ACTIVE: begin
                if (!buffer_mode || fill_stop ||
                    (fill_method_select && manual_stop)) begin
                    state_next = FILL_IDLE;
                end else if (fill_method_select && manual_start) begin
                    state_next = FILL_WAIT_SYNC;
                end
            end
            default: state_next = FILL_IDLE;
        endcase
    end

    // state and outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_reg <= FILL_IDLE;
            filling   <= 1'b0;
            fill_done <= 1'b0;
        end else begin
            state_reg <= state_next;
            filling   <= (state_next == FILL_ACTIVE);
            fill_done <= (state_reg == FILL_ACTIVE) &&
                         (state_next == FILL_IDLE);
        end
    end

    // no automatic start in manual mode
    AST_FILL_MANUAL_NO_AUTO: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (state_reg == FILL_IDLE && fill_method_select && !manual_start)
        |=> !filling) else $error("manual mode started fill on its own");

endmodule : fftc_fill_ctrl
`default_nettype wire

// [fftc_pkg.sv]
// constants and types shared by the fill and transmit-done control block
package fftc_pkg;

    // register indices; byte address is four times the index
    localparam logic [7:0] FFTC_CFG_IDX    = 8'h0E;
    localparam logic [7:0] FFTC_STATUS_IDX = 8'h10;
    localparam logic [7:0] FFTC_MASK_IDX   = 8'h11;

    // reset values
    localparam logic [7:0] FFTC_CFG_RESET  = 8'h01;

    // field positions of fill_tx_pll_signal_irq_cfg
    localparam int FFTC_BIT_FILL_METHOD  = 7;
    localparam int FFTC_BIT_FILL_CTRL    = 6;
    localparam int FFTC_BIT_TX_DONE      = 5;
    localparam int FFTC_BIT_TX_START_SEL = 4;
    localparam int FFTC_BIT_RSVD_EN      = 3;
    localparam int FFTC_BIT_SIGNAL_FLAG  = 2;
    localparam int FFTC_BIT_LOCK_STAT    = 1;
    localparam int FFTC_BIT_LOCK_EN      = 0;

    // interrupt status and mask layout
    localparam int FFTC_EV_W          = 4;
    localparam int FFTC_EV_TX_DONE    = 0;
    localparam int FFTC_EV_FILL_DONE  = 1;
    localparam int FFTC_EV_SIGNAL     = 2;
    localparam int FFTC_EV_QUEUE_EMPT = 3;

    // data mode code of buffer mode
    localparam logic [1:0] FFTC_MODE_BUFFER = 2'h1;

    // AXI response codes
    localparam logic [1:0] FFTC_RESP_OKAY   = 2'h0;
    localparam logic [1:0] FFTC_RESP_SLVERR = 2'h2;

    // fill sequencer states
    typedef enum logic [1:0] {
        FILL_IDLE      = 2'b00,
        FILL_WAIT_SYNC = 2'b01,
        FILL_ACTIVE    = 2'b10
    } fftc_fill_state_t;

    // byte address of a register index
    function automatic logic [7:0] fftc_byte_addr(input logic [7:0] idx);
        return {idx[5:0], 2'h0};
    endfunction : fftc_byte_addr

endpackage : fftc_pkg

// [fftc_top.sv]
// fill and transmit-done control register block with AXI4-Lite slave
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module fftc_top #(
    parameter int ADDR_W = 8
) (
    input  wire logic              aclk,
    input  wire logic              aresetn,
    // AXI4-Lite slave
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,
    input  wire logic              s_axi_awvalid,
    output var  logic              s_axi_awready,
    input  wire logic [31:0]       s_axi_wdata,
    input  wire logic [3:0]        s_axi_wstrb,
    input  wire logic              s_axi_wvalid,
    output var  logic              s_axi_wready,
    output var  logic [1:0]        s_axi_bresp,
    output var  logic              s_axi_bvalid,
    input  wire logic              s_axi_bready,
    input  wire logic [ADDR_W-1:0] s_axi_araddr,
    input  wire logic              s_axi_arvalid,
    output var  logic              s_axi_arready,
    output var  logic [31:0]       s_axi_rdata,
    output var  logic [1:0]        s_axi_rresp,
    output var  logic              s_axi_rvalid,
    input  wire logic              s_axi_rready,
    // device side
    input  wire logic [1:0]        data_mode,
    input  wire logic              sync_detected,
    input  wire logic              fill_stop,
    input  wire logic              tx_enable,
    input  wire logic              queue_empty,
    input  wire logic              queue_full,
    input  wire logic              tx_last_bit_out,
    input  wire logic              signal_above,
    input  wire logic              synth_locked,
    output var  logic              fill_enable,
    output var  logic              tx_start,
    output var  logic              interrupt_line_zero,
    output var  logic              irq
);
    import fftc_pkg::*;

    // the address must reach the highest register
    if (ADDR_W < 8 || ADDR_W > 32) begin : g_addr_check
        $error("ADDR_W must lie between 8 and 32");
    end

    // write channel state
    logic              aw_got_reg;
    logic              w_got_reg;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]       w_data_reg;
    logic [3:0]        w_strb_reg;
    logic              wr_fire;

    // register fields
    logic                 fill_method_select_reg;
    logic                 interrupt_line_zero_tx_start_sel_reg;
    logic                 rsvd_en_reg;
    logic                 synth_lock_enable_reg;
    logic                 signal_strength_irq_flag_reg;
    logic [FFTC_EV_W-1:0] status_reg;
    logic [FFTC_EV_W-1:0] mask_reg;
    logic [FFTC_EV_W-1:0] status_next;
    logic [FFTC_EV_W-1:0] events;

    // decoded writes
    logic       wr_cfg;
    logic       wr_status;
    logic       wr_mask;
    logic       wr_ok;
    logic       manual_start;
    logic       manual_stop;
    logic       buffer_mode;
    logic       filling;
    logic       fill_done;
    logic       transmit_complete;
    logic       tx_done_d_reg;
    logic       line_zero_d_reg;
    logic [7:0] cfg_read;

    assign buffer_mode = (data_mode == FFTC_MODE_BUFFER);

    // true when the byte address selects the given index
    function automatic logic hits(input logic [ADDR_W-1:0] a,
                                  input logic [7:0]        idx);
        return a == ADDR_W'(fftc_byte_addr(idx));
    endfunction : hits

    // write address and data taken in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            w_got_reg     <= 1'b0;
            aw_addr_reg   <= '0;
            w_data_reg    <= 32'h0000_0000;
            w_strb_reg    <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_got_reg    <= 1'b1;
                aw_addr_reg   <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_got_reg    <= 1'b1;
                w_data_reg   <= s_axi_wdata;
                w_strb_reg   <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
            end
            if (s_axi_bvalid && s_axi_bready) begin
                s_axi_awready <= 1'b1;
                s_axi_wready  <= 1'b1;
            end
        end
    end

    // write decode, in the same cycle as both halves are held
    assign wr_fire   = aw_got_reg && w_got_reg && !s_axi_bvalid;
    assign wr_cfg    = wr_fire && hits(aw_addr_reg, FFTC_CFG_IDX);
    assign wr_status = wr_fire && hits(aw_addr_reg, FFTC_STATUS_IDX);
    assign wr_mask   = wr_fire && hits(aw_addr_reg, FFTC_MASK_IDX);
    assign wr_ok     = w_strb_reg[0];

    // write response
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= FFTC_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (wr_cfg || wr_status || wr_mask) ?
                            FFTC_RESP_OKAY : FFTC_RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    assign manual_start = wr_cfg && wr_ok && fill_method_select_reg &&
                          w_data_reg[FFTC_BIT_FILL_CTRL];
    assign manual_stop  = wr_cfg && wr_ok && fill_method_select_reg &&
                          !w_data_reg[FFTC_BIT_FILL_CTRL];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fill_method_select_reg <= FFTC_CFG_RESET[FFTC_BIT_FILL_METHOD];
            interrupt_line_zero_tx_start_sel_reg  <= FFTC_CFG_RESET[FFTC_BIT_TX_START_SEL];
            rsvd_en_reg            <= FFTC_CFG_RESET[FFTC_BIT_RSVD_EN];
            synth_lock_enable_reg  <= FFTC_CFG_RESET[FFTC_BIT_LOCK_EN];
        end else if (wr_cfg && wr_ok) begin
            fill_method_select_reg <= w_data_reg[FFTC_BIT_FILL_METHOD];
            interrupt_line_zero_tx_start_sel_reg  <= w_data_reg[FFTC_BIT_TX_START_SEL];
            rsvd_en_reg            <= w_data_reg[FFTC_BIT_RSVD_EN];
            synth_lock_enable_reg  <= w_data_reg[FFTC_BIT_LOCK_EN];
        end
    end

    // signal flag: set wins over write-one clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            signal_strength_irq_flag_reg <=
                FFTC_CFG_RESET[FFTC_BIT_SIGNAL_FLAG];
        end else if (rsvd_en_reg && signal_above) begin
            signal_strength_irq_flag_reg <= 1'b1;
        end else if (wr_cfg && wr_ok && w_data_reg[FFTC_BIT_SIGNAL_FLAG]) begin
            signal_strength_irq_flag_reg <= 1'b0;
        end
    end

    // fill status reads only in automatic mode
    // bits 5 and 1 are read only
    always_comb begin
        cfg_read                        = 8'h00;
        cfg_read[FFTC_BIT_FILL_METHOD]  = fill_method_select_reg;
        cfg_read[FFTC_BIT_FILL_CTRL]    = filling && !fill_method_select_reg;
        cfg_read[FFTC_BIT_TX_DONE]      = transmit_complete;
        cfg_read[FFTC_BIT_TX_START_SEL] = interrupt_line_zero_tx_start_sel_reg;
        cfg_read[FFTC_BIT_RSVD_EN]      = rsvd_en_reg;
        cfg_read[FFTC_BIT_SIGNAL_FLAG]  = signal_strength_irq_flag_reg;
        cfg_read[FFTC_BIT_LOCK_STAT]    = synth_lock_enable_reg && synth_locked;
        cfg_read[FFTC_BIT_LOCK_EN]      = synth_lock_enable_reg;
    end

    // read channel, one read at a time
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= FFTC_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rresp   <= FFTC_RESP_OKAY;
            if (hits(s_axi_araddr, FFTC_CFG_IDX)) begin
                s_axi_rdata <= {24'h00_0000, cfg_read};
            end else if (hits(s_axi_araddr, FFTC_STATUS_IDX)) begin
                s_axi_rdata <= {28'h000_0000, status_reg};
            end else if (hits(s_axi_araddr, FFTC_MASK_IDX)) begin
                s_axi_rdata <= {28'h000_0000, mask_reg};
            end else begin
                s_axi_rdata <= 32'h0000_0000;
                s_axi_rresp <= FFTC_RESP_SLVERR;
            end
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid  <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    // fill sequencer
    fftc_fill_ctrl u_fill (
        .aclk               (aclk),
        .aresetn            (aresetn),
        .buffer_mode        (buffer_mode),
        .fill_method_select (fill_method_select_reg),
        .manual_start       (manual_start),
        .manual_stop        (manual_stop),
        .sync_detected      (sync_detected),
        .fill_stop          (fill_stop),
        .filling            (filling),
        .fill_done          (fill_done)
    );

    assign fill_enable = filling;

    // transmit start and completion
    fftc_tx_ctrl u_tx (
        .aclk                       (aclk),
        .aresetn                    (aresetn),
        .buffer_mode                (buffer_mode),
        .tx_enable                  (tx_enable),
        .interrupt_line_zero_transmit_start_select (interrupt_line_zero_tx_start_sel_reg),
        .queue_empty                (queue_empty),
        .queue_full                 (queue_full),
        .tx_last_bit_out            (tx_last_bit_out),
        .tx_start                   (tx_start),
        .transmit_complete          (transmit_complete),
        .interrupt_line_zero        (interrupt_line_zero)
    );

    // edge history for event detection
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_done_d_reg   <= 1'b0;
            line_zero_d_reg <= 1'b0;
        end else begin
            tx_done_d_reg   <= transmit_complete;
            line_zero_d_reg <= interrupt_line_zero;
        end
    end

    always_comb begin
        events                     = '0;
        events[FFTC_EV_TX_DONE]    = transmit_complete && !tx_done_d_reg;
        events[FFTC_EV_FILL_DONE]  = fill_done;
        events[FFTC_EV_SIGNAL]     = rsvd_en_reg && signal_above &&
                                     !signal_strength_irq_flag_reg;
        events[FFTC_EV_QUEUE_EMPT] = interrupt_line_zero && !line_zero_d_reg;
    end

    // sticky status: a new event wins over write-one clear
    always_comb begin
        status_next = status_reg;
        if (wr_status && wr_ok) begin
            status_next = status_reg & ~w_data_reg[FFTC_EV_W-1:0];
        end
        status_next = status_next | events;
    end

    // status, mask and interrupt output
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            status_reg <= '0;
            mask_reg   <= '0;
            irq        <= 1'b0;
        end else begin
            status_reg <= status_next;
            if (wr_mask && wr_ok) begin
                mask_reg <= w_data_reg[FFTC_EV_W-1:0];
            end
            irq <= |(status_reg & mask_reg);
        end
    end

    // assertions on the block's own behaviour
    AST_CFG_RESET: assert property (@(posedge aclk)
        $rose(aresetn) |-> cfg_read[FFTC_BIT_LOCK_EN] &&
        !cfg_read[FFTC_BIT_FILL_METHOD] && !cfg_read[FFTC_BIT_RSVD_EN])
        else $error("configuration not at power-on value");

    AST_NOT_BUFFER_NO_FILL: assert property (@(posedge aclk)
        disable iff (!aresetn)
        !buffer_mode ##1 !buffer_mode |-> !fill_enable)
        else $error("fill active outside buffer mode");

    AST_AUTO_SYNC_FILL: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (buffer_mode && !fill_method_select_reg && !filling && sync_detected)
        |=> fill_enable)
        else $error("sync word did not start automatic fill");

    AST_AUTO_STATUS_READ: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (s_axi_arvalid && s_axi_arready && !fill_method_select_reg &&
         hits(s_axi_araddr, FFTC_CFG_IDX)) |=>
        s_axi_rdata[FFTC_BIT_FILL_CTRL] == $past(fill_enable))
        else $error("fill status bit disagrees with fill state");

    AST_MANUAL_STOP: assert property (@(posedge aclk)
        disable iff (!aresetn)
        manual_stop |=> !fill_enable ##1 !fill_enable)
        else $error("manual stop did not end fill");

    AST_MANUAL_CLEARS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        manual_start && !sync_detected |=> !fill_enable)
        else $error("manual start filled without fresh sync");

    AST_TX_DONE_SETS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(transmit_complete) |=> status_reg[FFTC_EV_TX_DONE])
        else $error("transmit complete lost its status event");

    AST_IRQ_FOLLOWS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        (status_reg[FFTC_EV_TX_DONE] && mask_reg[FFTC_EV_TX_DONE]) |=> irq)
        else $error("unmasked transmit complete gave no interrupt");

    AST_LINE_ZERO: assert property (@(posedge aclk)
        disable iff (!aresetn)
        buffer_mode && queue_empty |=> interrupt_line_zero)
        else $error("line zero missed queue empty");

    AST_SIGNAL_FLAG: assert property (@(posedge aclk)
        disable iff (!aresetn)
        rsvd_en_reg && signal_above |=> signal_strength_irq_flag_reg)
        else $error("signal flag not set above threshold");

    AST_RO_BITS: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_cfg && !tx_enable && !tx_last_bit_out |=>
        $stable(transmit_complete))
        else $error("host write changed a read-only bit");

    AST_BRESP_ONE: assert property (@(posedge aclk)
        disable iff (!aresetn)
        wr_fire |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
        else $error("write response not raised after write");

endmodule : fftc_top
`default_nettype wire

// [fftc_tx_ctrl.sv]
// transmit start condition and transmit complete tracking
`timescale 1ns/1ps
`default_nettype none
module fftc_tx_ctrl (
    input  wire logic aclk,
    input  wire logic aresetn,
    input  wire logic buffer_mode,
    input  wire logic tx_enable,
    input  wire logic interrupt_line_zero_transmit_start_select,
    input  wire logic queue_empty,
    input  wire logic queue_full,
    input  wire logic tx_last_bit_out,
    output var  logic tx_start,
    output var  logic transmit_complete,
    output var  logic interrupt_line_zero
);
    import fftc_pkg::*;

    logic busy_reg;
    logic start_cond;

    // start when not empty or when full
    assign start_cond = buffer_mode && tx_enable && !busy_reg && !tx_start &&
        (interrupt_line_zero_transmit_start_select ? !queue_empty : queue_full);

    // transmit bookkeeping
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            busy_reg          <= 1'b0;
            tx_start          <= 1'b0;
            transmit_complete <= 1'b0;
        end else begin
            tx_start <= start_cond;
            if (start_cond) begin
                busy_reg          <= 1'b1;
                transmit_complete <= 1'b0;
            end else if (busy_reg && tx_last_bit_out) begin
                busy_reg          <= 1'b0;
                transmit_complete <= 1'b1;
            end
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            interrupt_line_zero <= 1'b0;
        end else begin
            interrupt_line_zero <= buffer_mode && queue_empty;
        end
    end

    AST_TX_START_COND: assert property (@(posedge aclk)
        disable iff (!aresetn)
        $rose(tx_start) |-> $past(buffer_mode) &&
        ($past(interrupt_line_zero_transmit_start_select) ? !$past(queue_empty)
                                            : $past(queue_full)))
        else $error("transmit started without its queue condition");

endmodule : fftc_tx_ctrl
`default_nettype wire

// [test_fifo_fill_and_tx_done_control.sv]
// register-level bench for the fill and transmit-done control block
`timescale 1ns/1ps
`default_nettype none
module test_fifo_fill_and_tx_done_control;
    import fftc_pkg::*;
    localparam logic [7:0] CFG = {FFTC_CFG_IDX[5:0], 2'h0};
    localparam logic [7:0] STA = {FFTC_STATUS_IDX[5:0], 2'h0};
    localparam logic [7:0] MSK = {FFTC_MASK_IDX[5:0], 2'h0};
    localparam logic [7:0] BAD = 8'h3C;
    logic        aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
    logic        s_axi_wready, s_axi_bvalid, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, sync_detected, fill_stop, tx_enable;
    logic        queue_empty, queue_full, tx_last_bit_out, signal_above;
    logic        synth_locked, fill_enable, tx_start, interrupt_line_zero, irq;
    logic [7:0]  s_axi_awaddr, s_axi_araddr, starts;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0]  s_axi_bresp, s_axi_rresp, data_mode;
    int          failures, check_count;
    wire logic [7:0] flags = {4'h0, irq, interrupt_line_zero, 1'b0, fill_enable};

    fftc_top u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
        .s_axi_awready, .s_axi_wdata, .s_axi_wstrb(4'hF), .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready(1'b1),
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
        .s_axi_rresp, .s_axi_rvalid, .s_axi_rready(1'b1), .data_mode,
        .sync_detected, .fill_stop, .tx_enable, .queue_empty, .queue_full,
        .tx_last_bit_out, .signal_above, .synth_locked, .fill_enable,
        .tx_start, .interrupt_line_zero, .irq);

    // clock and transmit start counter
    always #20 aclk = ~aclk;
    always @(posedge aclk) if (tx_start === 1'b1) starts <= starts + 8'h01;

    task automatic chk(input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            failures++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask : chk
    task automatic tk(input int n);
        repeat (n) @(posedge aclk);
    endtask : tk
    // flag snapshot away from the clock edge
    task automatic fl(input logic [7:0] m, input logic [7:0] e);
        @(negedge aclk);
        chk(flags & m, e);
        @(posedge aclk);
    endtask : fl
    task automatic wr(input logic [7:0] a, input logic [7:0] d,
                      input logic [1:0] er);
        logic aw, w, b;
        logic [1:0] r;
        aw = 0; w = 0; b = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        while (!(aw && w)) begin
            @(negedge aclk);
            if (s_axi_awready && s_axi_awvalid) aw = 1;
            if (s_axi_wready && s_axi_wvalid) w = 1;
            @(posedge aclk);
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        while (!b) begin
            @(negedge aclk);
            b = s_axi_bvalid;
            r = s_axi_bresp;
            @(posedge aclk);
        end
        chk({6'h0, r}, {6'h0, er});
    endtask : wr
    task automatic rc(input logic [7:0] a, input logic [7:0] e,
                      input logic [7:0] m, input logic [1:0] er);
        logic ar, got;
        logic [7:0] d;
        logic [1:0] r;
        ar = 0; got = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        while (!got) begin
            @(negedge aclk);
            if (s_axi_arready && s_axi_arvalid) ar = 1;
            if (s_axi_rvalid) begin
                got = 1;
                d = s_axi_rdata[7:0];
                r = s_axi_rresp;
            end
            @(posedge aclk);
            if (ar) begin
                s_axi_arvalid <= 1'b0;
                ar = 0;
            end
        end
        chk(d & m, e);
        chk({6'h0, r}, {6'h0, er});
    endtask : rc
    task automatic end_of_test;
        $display("comparisons %0d mismatches %0d", check_count, failures);
        if (failures == 0 && check_count > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : end_of_test

    // watchdog against a hung handshake
    initial begin
        tk(20000);
        failures++;
        end_of_test;
    end
    // main sequence
    initial begin
        {aclk, aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} = '0;
        {sync_detected, fill_stop, tx_enable, queue_empty, queue_full} = '0;
        {tx_last_bit_out, signal_above, synth_locked, data_mode} = '0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata, starts} = '0;
        tk(3);
        aresetn <= 1'b1;
        rc(CFG, 8'h01, 8'hFF, 2'h0);
        rc(BAD, 8'h00, 8'hFF, 2'h2);
        wr(BAD, 8'hFF, 2'h2);
        wr(CFG, 8'h22, 2'h0);
        rc(CFG, 8'h00, 8'hFF, 2'h0);
        rc(MSK, 8'h00, 8'hFF, 2'h0);
        wr(CFG, 8'h08, 2'h0);
        signal_above <= 1'b1;
        tk(2);
        rc(CFG, 8'h0C, 8'hFF, 2'h0);
        signal_above <= 1'b0;
        wr(CFG, 8'h0C, 2'h0);
        rc(CFG, 8'h08, 8'hFF, 2'h0);
        rc(STA, 8'h04, 8'h04, 2'h0);
        wr(STA, 8'h0F, 2'h0);
        $display("register test finished");
        data_mode <= FFTC_MODE_BUFFER;
        wr(MSK, 8'h02, 2'h0);
        sync_detected <= 1'b1;
        tk(1);
        sync_detected <= 1'b0;
        fl(8'h01, 8'h01);
        rc(CFG, 8'h48, 8'hFF, 2'h0);
        fill_stop <= 1'b1;
        tk(1);
        fill_stop <= 1'b0;
        tk(3);
        rc(CFG, 8'h08, 8'hFF, 2'h0);
        rc(STA, 8'h02, 8'h02, 2'h0);
        fl(8'h09, 8'h08);
        wr(STA, 8'h02, 2'h0);
        fl(8'h08, 8'h00);
        data_mode <= 2'h0;
        sync_detected <= 1'b1;
        tk(1);
        sync_detected <= 1'b0;
        fl(8'h01, 8'h00);
        $display("automatic fill test finished");
        data_mode <= FFTC_MODE_BUFFER;
        wr(CFG, 8'h88, 2'h0);
        wr(CFG, 8'hC8, 2'h0);
        fl(8'h01, 8'h00);
        rc(CFG, 8'h88, 8'hFF, 2'h0);
        sync_detected <= 1'b1;
        tk(1);
        sync_detected <= 1'b0;
        fl(8'h01, 8'h01);
        wr(CFG, 8'h88, 2'h0);
        fl(8'h01, 8'h00);
        sync_detected <= 1'b1;
        tk(1);
        sync_detected <= 1'b0;
        fl(8'h01, 8'h00);
        $display("manual fill test finished");
        for (int i = 0; i < 2; i++) begin
            wr(CFG, (i == 1) ? 8'h18 : 8'h08, 2'h0);
            queue_empty <= (i == 1);
            tx_enable <= 1'b1;
            tk(4);
            chk(starts, i[7:0]);
            if (i == 1) fl(8'h04, 8'h04);
            queue_empty <= 1'b0;
            queue_full <= (i == 0);
            tk(3);
            chk(starts, i[7:0] + 8'h01);
            queue_full <= 1'b0;
            tx_enable <= 1'b0;
            rc(CFG, 8'h00, 8'h20, 2'h0);
            tx_last_bit_out <= 1'b1;
            tk(1);
            tx_last_bit_out <= 1'b0;
            tk(2);
            rc(CFG, 8'h20, 8'h20, 2'h0);
            rc(STA, 8'h01, 8'h01, 2'h0);
            wr(STA, 8'h01, 2'h0);
        end
        $display("transmit test finished");
        end_of_test;
    end
endmodule : test_fifo_fill_and_tx_done_control
`default_nettype wire
